// ### src/lvds_cfg_pkg.sv
// package: register map, field layout and lane constants for lvds output config
package lvds_cfg_pkg;

   // register indices and their byte addresses on apb
   localparam logic [7:0] IDX_SOFT_RESET = 8'h09;
   localparam logic [7:0] IDX_FORMAT_POLARITY = 8'h18;
   localparam logic [7:0] IDX_LEVEL_SWING = 8'h19;
   localparam logic [7:0] IDX_PIN_ORDER_TERM = 8'h1a;
   localparam logic [7:0] IDX_COMMON_MODE_TRIM = 8'h1b;
   localparam logic [7:0] IDX_LANE_STATUS = 8'h1f;

   // field positions
   localparam int ENABLE_INVERT_BIT = 7;
   localparam int HSYNC_INVERT_BIT = 6;
   localparam int VSYNC_INVERT_BIT = 5;
   localparam int RESERVED_POL_BIT = 4;
   localparam int WIDE_COLOR_BIT = 3;
   localparam int LSB_PACKING_BIT = 1;
   localparam int COMMON_MODE_SEL_BIT = 6;
   localparam int SWING_LSB = 2;
   localparam int PIN_REVERSE_BIT = 5;
   localparam int TERMINATION_BIT = 1;
   localparam int CM_TRIM_LSB = 4;
   localparam int SOFT_RESET_BIT = 0;

   // reset values and writable-bit masks
   localparam logic [7:0] FORMAT_POLARITY_RST = 8'h70;
   localparam logic [7:0] FORMAT_POLARITY_MASK = 8'hfa;
   localparam logic [7:0] LEVEL_SWING_RST = 8'h04;
   localparam logic [7:0] LEVEL_SWING_MASK = 8'h4c;
   localparam logic [7:0] PIN_ORDER_TERM_RST = 8'h02;
   localparam logic [7:0] PIN_ORDER_TERM_MASK = 8'h22;
   localparam logic [7:0] COMMON_MODE_TRIM_RST = 8'h00;
   localparam logic [7:0] COMMON_MODE_TRIM_MASK = 8'h30;

   // lane layout: index 4 is the clock lane
   localparam int LANE_BITS = 7;
   localparam int LANE_COUNT = 5;
   localparam int CLOCK_LANE = 4;
   localparam logic [6:0] CLOCK_PATTERN = 7'h63;

   typedef logic [LANE_COUNT-1:0][LANE_BITS-1:0] lane_words_t;

   // byte address of a register index
   function automatic logic [7:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx[5:0], 2'b00};
   endfunction : reg_addr

endpackage : lvds_cfg_pkg

// ### src/lane_bus_if.sv
// interface: parallel lane words passed from the mapper to the pin-order stage
`timescale 1ns/1ps
`default_nettype none
interface lane_bus_if;
   lvds_cfg_pkg::lane_words_t words;
   logic [lvds_cfg_pkg::LANE_COUNT-1:0] lane_en;
   modport src (output words, output lane_en);
   modport dst (input words, input lane_en);
endinterface : lane_bus_if
`default_nettype wire

// ### src/lvds_pixel_mapper.sv
// module: packs one pixel plus syncs into the seven-bit lane words
`timescale 1ns/1ps
`default_nettype none
module lvds_pixel_mapper (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pipe_clear,
   input wire logic enable_out_invert,
   input wire logic hsync_out_invert,
   input wire logic vsync_out_invert,
   input wire logic wide_color_lane_enable,
   input wire logic lane4_lsb_packing,
   input wire logic pix_de,
   input wire logic pix_hsync,
   input wire logic pix_vsync,
   input wire logic [7:0] pix_red,
   input wire logic [7:0] pix_green,
   input wire logic [7:0] pix_blue,
   lane_bus_if.src lanes
);
   typedef struct packed {
      lvds_cfg_pkg::lane_words_t words;
      logic [lvds_cfg_pkg::LANE_COUNT-1:0] lane_en;
   } mapper_state_s;

   mapper_state_s state_q;
   mapper_state_s state_d;

   // six bits for lanes 0..2, two bits for lane 3
   function automatic logic [5:0] main_bits(input logic [7:0] c, input logic lsb_pack);
      main_bits = lsb_pack ? c[7:2] : c[5:0];
   endfunction : main_bits

   function automatic logic [1:0] extra_bits(input logic [7:0] c, input logic lsb_pack);
      extra_bits = lsb_pack ? c[1:0] : c[7:6];
   endfunction : extra_bits

   always_comb begin
      logic [5:0] r6;
      logic [5:0] g6;
      logic [5:0] b6;
      logic [1:0] r2;
      logic [1:0] g2;
      logic [1:0] b2;
      logic de_o;
      logic hs_o;
      logic vs_o;
      r6 = main_bits(pix_red, lane4_lsb_packing);
      g6 = main_bits(pix_green, lane4_lsb_packing);
      b6 = main_bits(pix_blue, lane4_lsb_packing);
      r2 = extra_bits(pix_red, lane4_lsb_packing);
      g2 = extra_bits(pix_green, lane4_lsb_packing);
      b2 = extra_bits(pix_blue, lane4_lsb_packing);
      de_o = pix_de ^ enable_out_invert;
      hs_o = pix_hsync ^ hsync_out_invert;
      vs_o = pix_vsync ^ vsync_out_invert;
      state_d = state_q;
      state_d.words[0] = {g6[0], r6};
      state_d.words[1] = {b6[1:0], g6[5:1]};
      state_d.words[2] = {de_o, vs_o, hs_o, b6[5:2]};
      state_d.words[3] = {1'b0, b2, g2, r2};
      state_d.words[lvds_cfg_pkg::CLOCK_LANE] = lvds_cfg_pkg::CLOCK_PATTERN;
      state_d.lane_en = 5'h1_7;
      // lane 3 on only at 24 bpp
      state_d.lane_en[3] = wide_color_lane_enable;
      if (!wide_color_lane_enable) begin
         // lane 3 extra bits dropped at 18 bpp
         state_d.words[3] = 7'h00;
      end
      if (pipe_clear) begin
         state_d = '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign lanes.words = state_q.words;
   assign lanes.lane_en = state_q.lane_en;

endmodule : lvds_pixel_mapper
`default_nettype wire

// ### src/lvds_lane_order.sv
// module: optional reversal of lane pin order before the output pins
`timescale 1ns/1ps
`default_nettype none
module lvds_lane_order (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pipe_clear,
   input wire logic pin_order_reverse,
   lane_bus_if.dst lanes,
   output logic [4:0][6:0] out_words,
   output logic [4:0] out_en
);
   typedef struct packed {
      logic [4:0][6:0] words;
      logic [4:0] en;
   } order_state_s;

   order_state_s state_q;
   order_state_s state_d;

   always_comb begin
      state_d.words = lanes.words;
      state_d.en = lanes.lane_en;
      if (pin_order_reverse) begin
         state_d.words[0] = lanes.words[3];
         state_d.words[3] = lanes.words[0];
         state_d.words[1] = lanes.words[lvds_cfg_pkg::CLOCK_LANE];
         state_d.words[lvds_cfg_pkg::CLOCK_LANE] = lanes.words[1];
         state_d.en[0] = lanes.lane_en[3];
         state_d.en[3] = lanes.lane_en[0];
         state_d.en[1] = lanes.lane_en[lvds_cfg_pkg::CLOCK_LANE];
         state_d.en[lvds_cfg_pkg::CLOCK_LANE] = lanes.lane_en[1];
      end
      if (pipe_clear) begin
         state_d = '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign out_words = state_q.words;
   assign out_en = state_q.en;

endmodule : lvds_lane_order
`default_nettype wire

// ### src/lvds_output_config_regs.sv
// top: apb register bank and output-side control of the lvds transmit channel
//
// Operation
// - enable bit 7 inverts data-enable output
// - hsync bit 6 inverts sync, resets set
// - vsync bit 5 inverts sync, resets set
// - bit 3 selects 24 bpp, lane 3
// - bit 1 puts lsbs on lane 3
// - 18 bpp with lsb packing drops lsbs
// - reverse swaps lanes 0/3 and 1/clock
// - common-mode select: 1.2 V or 0.9 V
// - two-bit swing field, reset 01, driven out
// - termination bit: 100 or 200 ohm
// - two-bit common-mode trim, reset 00
`timescale 1ns/1ps
`default_nettype none
module lvds_output_config_regs #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pix_de,
   input wire logic pix_hsync,
   input wire logic pix_vsync,
   input wire logic [7:0] pix_red,
   input wire logic [7:0] pix_green,
   input wire logic [7:0] pix_blue,
   output logic [6:0] data_lane0_word,
   output logic [6:0] data_lane1_word,
   output logic [6:0] data_lane2_word,
   output logic [6:0] data_lane3_word,
   output logic [6:0] clock_lane_word,
   output logic [4:0] lane_enable,
   output logic common_mode_select,
   output logic [1:0] output_swing_sel,
   output logic termination_select,
   output logic [1:0] common_mode_trim
);
   typedef enum logic [1:0] {
      REG_NONE = 2'b00,
      REG_RW = 2'b01,
      REG_WO = 2'b10
   } reg_kind_e;

   typedef struct packed {
      logic [7:0] format_polarity;
      logic [7:0] level_swing;
      logic [7:0] pin_order_term;
      logic [7:0] cm_trim;
      logic soft_reset;
      logic [31:0] rdata;
   } regs_state_s;

   regs_state_s state_q;
   regs_state_s state_d;

   logic [4:0][6:0] pin_words;
   logic [4:0] pin_en;
   logic [7:0] addr_byte;
   logic addr_hit;
   logic addr_aligned;
   logic setup_phase;
   logic access_phase;

   lane_bus_if lanes ();

   // which register a byte address selects
   function automatic reg_kind_e decode_kind(input logic [7:0] a);
      if (a == lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_FORMAT_POLARITY)
          || a == lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_LEVEL_SWING)
          || a == lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_PIN_ORDER_TERM)
          || a == lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_COMMON_MODE_TRIM)
          || a == lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_LANE_STATUS)) begin
         decode_kind = REG_RW;
      end else if (a == lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_SOFT_RESET)) begin
         decode_kind = REG_WO;
      end else begin
         decode_kind = REG_NONE;
      end
   endfunction : decode_kind

   // masked write of one byte lane
   function automatic logic [7:0] merge(input logic [7:0] wdata, input logic [7:0] mask);
      merge = wdata & mask;
   endfunction : merge

   assign addr_byte = 8'(paddr);
   assign addr_aligned = (addr_byte[1:0] == 2'b00) && (paddr == ADDR_W'(addr_byte));
   assign addr_hit = addr_aligned && (decode_kind(addr_byte) != REG_NONE);
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;

   // zero wait states; error on any unmapped or misaligned address
   assign pready = 1'b1;
   assign pslverr = access_phase && !addr_hit;

   always_comb begin
      logic [7:0] rbyte;
      rbyte = 8'h00;
      state_d = state_q;
      state_d.soft_reset = 1'b0;
      if (setup_phase && !pwrite && addr_aligned) begin
         unique case (addr_byte)
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_FORMAT_POLARITY): begin
               rbyte = state_q.format_polarity;
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_LEVEL_SWING): begin
               rbyte = state_q.level_swing;
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_PIN_ORDER_TERM): begin
               rbyte = state_q.pin_order_term;
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_COMMON_MODE_TRIM): begin
               rbyte = state_q.cm_trim;
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_LANE_STATUS): begin
               rbyte = {3'b000, pin_en};
            end
            default: begin
               rbyte = 8'h00;
            end
         endcase
         state_d.rdata = {24'h00_0000, rbyte};
      end else if (setup_phase) begin
         state_d.rdata = 32'h0000_0000;
      end
      if (access_phase && pwrite && addr_hit && pstrb[0]) begin
         unique case (addr_byte)
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_FORMAT_POLARITY): begin
               state_d.format_polarity = merge(pwdata[7:0], lvds_cfg_pkg::FORMAT_POLARITY_MASK);
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_LEVEL_SWING): begin
               state_d.level_swing = merge(pwdata[7:0], lvds_cfg_pkg::LEVEL_SWING_MASK);
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_PIN_ORDER_TERM): begin
               state_d.pin_order_term = merge(pwdata[7:0], lvds_cfg_pkg::PIN_ORDER_TERM_MASK);
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_COMMON_MODE_TRIM): begin
               state_d.cm_trim = merge(pwdata[7:0], lvds_cfg_pkg::COMMON_MODE_TRIM_MASK);
            end
            lvds_cfg_pkg::reg_addr(lvds_cfg_pkg::IDX_SOFT_RESET): begin
               state_d.soft_reset = pwdata[lvds_cfg_pkg::SOFT_RESET_BIT];
            end
            default: begin
               state_d.rdata = state_q.rdata;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q.format_polarity <= lvds_cfg_pkg::FORMAT_POLARITY_RST;
         state_q.level_swing <= lvds_cfg_pkg::LEVEL_SWING_RST;
         state_q.pin_order_term <= lvds_cfg_pkg::PIN_ORDER_TERM_RST;
         state_q.cm_trim <= lvds_cfg_pkg::COMMON_MODE_TRIM_RST;
         state_q.soft_reset <= 1'b0;
         state_q.rdata <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
      end
   end

   assign prdata = state_q.rdata;

   lvds_pixel_mapper u_mapper (
      .clk(clk),
      .arst_n(arst_n),
      .pipe_clear(state_q.soft_reset),
      .enable_out_invert(state_q.format_polarity[lvds_cfg_pkg::ENABLE_INVERT_BIT]),
      .hsync_out_invert(state_q.format_polarity[lvds_cfg_pkg::HSYNC_INVERT_BIT]),
      .vsync_out_invert(state_q.format_polarity[lvds_cfg_pkg::VSYNC_INVERT_BIT]),
      .wide_color_lane_enable(state_q.format_polarity[lvds_cfg_pkg::WIDE_COLOR_BIT]),
      .lane4_lsb_packing(state_q.format_polarity[lvds_cfg_pkg::LSB_PACKING_BIT]),
      .pix_de(pix_de),
      .pix_hsync(pix_hsync),
      .pix_vsync(pix_vsync),
      .pix_red(pix_red),
      .pix_green(pix_green),
      .pix_blue(pix_blue),
      .lanes(lanes.src)
   );

   lvds_lane_order u_order (
      .clk(clk),
      .arst_n(arst_n),
      .pipe_clear(state_q.soft_reset),
      .pin_order_reverse(state_q.pin_order_term[lvds_cfg_pkg::PIN_REVERSE_BIT]),
      .lanes(lanes.dst),
      .out_words(pin_words),
      .out_en(pin_en)
   );

   assign data_lane0_word = pin_words[0];
   assign data_lane1_word = pin_words[1];
   assign data_lane2_word = pin_words[2];
   assign data_lane3_word = pin_words[3];
   assign clock_lane_word = pin_words[lvds_cfg_pkg::CLOCK_LANE];
   assign lane_enable = pin_en;

   assign common_mode_select = state_q.level_swing[lvds_cfg_pkg::COMMON_MODE_SEL_BIT];
   assign output_swing_sel = state_q.level_swing[lvds_cfg_pkg::SWING_LSB +: 2];
   assign termination_select = state_q.pin_order_term[lvds_cfg_pkg::TERMINATION_BIT];
   assign common_mode_trim = state_q.cm_trim[lvds_cfg_pkg::CM_TRIM_LSB +: 2];

endmodule : lvds_output_config_regs
`default_nettype wire

// ### test/lvds_panel_model.sv
// partner: panel receiver decoding the five lane words back into pixels
`timescale 1ns/1ps
`default_nettype none
module lvds_panel_model (
   input wire logic rev,
   input wire logic [6:0] lane0,
   input wire logic [6:0] lane1,
   input wire logic [6:0] lane2,
   input wire logic [6:0] lane3,
   input wire logic [6:0] lane_clk,
   input wire logic [4:0] en,
   output logic de,
   output logic hs,
   output logic vs,
   output logic clk_ok,
   output logic [5:0] red,
   output logic [5:0] green,
   output logic [5:0] blue,
   output logic [5:0] extra
);
   logic [6:0] l0, l1, l3, lc;
   logic [4:0] e;
   // undo board pin reversal, then unpack
   always_comb begin
      l0 = rev ? lane3 : lane0;
      l1 = rev ? lane_clk : lane1;
      l3 = rev ? lane0 : lane3;
      lc = rev ? lane1 : lane_clk;
      e = rev ? {en[1], en[0], en[2], en[4], en[3]} : en;
      red = l0[5:0];
      green = {l1[4:0], l0[6]};
      blue = {lane2[3:0], l1[6:5]};
      {de, vs, hs} = lane2[6:4];
      extra = e[3] ? l3[5:0] : ~l3[5:0];
      clk_ok = e[4] && (lc == 7'h63);
   end
endmodule : lvds_panel_model
`default_nettype wire

// ### test/lvds_output_config_regs_checker.sv
// checker: apb and output-side assertions for the lvds config bank
`timescale 1ns/1ps
`default_nettype none
module lvds_output_config_regs_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [6:0] data_lane1_word,
   input wire logic [6:0] data_lane3_word,
   input wire logic [6:0] clock_lane_word,
   input wire logic [4:0] lane_enable,
   input wire logic common_mode_select,
   input wire logic [1:0] output_swing_sel,
   input wire logic termination_select,
   input wire logic [1:0] common_mode_trim
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic mapped, wr_swing;
   assign mapped = paddr inside {8'h24, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h7c};
   assign wr_swing = psel && penable && pwrite && pstrb[0] && paddr == 8'h64;
   sequence s_wr(logic [7:0] a);
      psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   property p_swing;
      logic [1:0] v;
      (s_wr(8'h64), v = pwdata[3:2]) |=> output_swing_sel == v;
   endproperty
   a_ready_high: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
      else $error("error response does not match address map");
   a_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_swing_write: assert property (p_swing)
      else $error("swing output not the written value");
   a_swing_hold: assert property (!wr_swing |=> $stable(output_swing_sel))
      else $error("swing output changed without write");
   a_cm_write: assert property (s_wr(8'h64) |=> common_mode_select == $past(pwdata[6]))
      else $error("common-mode select not the written value");
   a_trim_write: assert property (s_wr(8'h6c) |=> common_mode_trim == $past(pwdata[5:4]))
      else $error("trim output not the written value");
   a_term_write: assert property (s_wr(8'h68) |=> termination_select == $past(pwdata[1]))
      else $error("termination output not the written value");
   a_lane_dark: assert property (!lane_enable[3] |-> data_lane3_word == 7'h0)
      else $error("disabled lane carries data");
   a_clock_shape: assert property (lane_enable[4] |->
      clock_lane_word == 7'h63 || data_lane1_word == 7'h63)
      else $error("no lane carries the clock pattern");
   a_enable_pairs: assert property (lane_enable[4] == lane_enable[1] &&
      lane_enable[2] == lane_enable[1])
      else $error("clock and base lane enables disagree");
   a_soft_clear: assert property (s_wr(8'h24) ##0 pwdata[0] |-> ##[1:3] lane_enable == 5'h0)
      else $error("soft reset did not clear the lanes");
endmodule : lvds_output_config_regs_checker
bind lvds_output_config_regs lvds_output_config_regs_checker #(.ADDR_W(ADDR_W)) u_chk (
   .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .data_lane1_word(data_lane1_word), .data_lane3_word(data_lane3_word),
   .clock_lane_word(clock_lane_word), .lane_enable(lane_enable),
   .common_mode_select(common_mode_select), .output_swing_sel(output_swing_sel),
   .termination_select(termination_select), .common_mode_trim(common_mode_trim));
`default_nettype wire

// ### test/tb.sv
// testbench: apb register access and lane mapping of the lvds config bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   logic clk, arst_n, psel, penable, pwrite, rev_q, pready, pslverr, e;
   logic pde, phs, pvs, cm_sel, term, m_de, m_hs, m_vs, m_ok;
   logic [7:0] paddr, r, g, b, a;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [6:0] w0, w1, w2, w3, wc;
   logic [4:0] en;
   logic [1:0] cm_trim, swing;
   logic [5:0] m_r, m_g, m_b, m3;
   logic [7:0] rst [4] = '{8'h70, 8'h04, 8'h02, 8'h00};
   logic [7:0] msk [4] = '{8'hfa, 8'h4c, 8'h22, 8'h30};
   int err_total, n_tests;
   lvds_output_config_regs dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pix_de(pde), .pix_hsync(phs), .pix_vsync(pvs),
      .pix_red(r), .pix_green(g), .pix_blue(b), .data_lane0_word(w0),
      .data_lane1_word(w1), .data_lane2_word(w2), .data_lane3_word(w3),
      .clock_lane_word(wc), .lane_enable(en), .common_mode_select(cm_sel),
      .output_swing_sel(swing), .termination_select(term), .common_mode_trim(cm_trim));
   lvds_panel_model pm (.rev(rev_q), .lane0(w0), .lane1(w1), .lane2(w2), .lane3(w3),
      .lane_clk(wc), .en(en), .de(m_de), .hs(m_hs), .vs(m_vs), .clk_ok(m_ok),
      .red(m_r), .green(m_g), .blue(m_b), .extra(m3));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic stop_test();
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic xe);
      apb(1'b0, ad, 32'h0);
      `CHK(q, x)
      `CHK(e, xe)
   endtask : rd
   task automatic pix(input logic [1:0] m, input logic [2:0] p);
      @(posedge clk);
      {pde, phs, pvs} <= {p[0], p[2], p[1]} ^ {m[0], m[0], m[1]};
      repeat (3) @(posedge clk);
      #1;
      `CHK({m_de, m_hs, m_vs}, {pde ^ p[2], phs ^ p[1], pvs ^ p[0]})
      `CHK({m_r, m_g, m_b}, m[0] ? {r[7:2], g[7:2], b[7:2]} : {r[5:0], g[5:0], b[5:0]})
      `CHK(m_ok, 1'b1)
      `CHK(en, m[1] ? 5'h1f : 5'h17)
      if (m[1]) begin
         `CHK(m3, m[0] ? {b[1:0], g[1:0], r[1:0]} : {b[7:6], g[7:6], r[7:6]})
      end else begin
         `CHK(w3, 7'h0)
      end
   endtask : pix
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      pde = 1'b1;
      phs = 1'b1;
      pvs = 1'b0;
      r = 8'hc9;
      g = 8'h5a;
      b = 8'h37;
      rev_q = 1'b0;
      err_total = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      `CHK({cm_sel, swing, term, cm_trim}, 6'b0_01_1_00)
      // trim reaches 01 before common-mode select is set
      for (int i = 3; i >= 0; i--) begin
         a = 8'h60 + 8'(4 * i);
         rd(a, 32'(rst[i]), 1'b0); // reset value
         apb(1'b1, a, 32'hff); // all ones written
         rd(a, 32'(msk[i]), 1'b0); // writable bits
         apb(1'b1, a, 32'h10); // trim left at 01
         rd(a, 32'(msk[i] & 8'h10), 1'b0); // cleared bits
      end
      `CHK(term, 1'b0)
      rd(8'h70, 32'h0, 1'b1); // unmapped place
      rd(8'h61, 32'h0, 1'b1); // misaligned place
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 8'h64, 32'(k << 2));
         apb(1'b1, 8'h6c, 32'(k << 4));
         `CHK({swing, cm_trim}, {2'(k), 2'(k)})
      end
      @(posedge clk);
      pstrb <= 4'he;
      apb(1'b1, 8'h6c, 32'h0); // byte strobe off
      @(posedge clk);
      pstrb <= 4'hf;
      rd(8'h6c, 32'h30, 1'b0); // strobed-off write ignored
      apb(1'b1, 8'h6c, 32'h10); // trim before low level
      apb(1'b1, 8'h64, 32'h44);
      `CHK({cm_sel, term}, 2'b10)
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, 8'h60, 32'({i[2:0], 1'b1, i[4], 1'b0, i[3], 1'b0}));
         pix(2'(i >> 3), i[2:0]);
      end
      apb(1'b1, 8'h60, 32'h18);
      rev_q = 1'b1;
      apb(1'b1, 8'h68, 32'h22);
      pix(2'b10, 3'b000); // reversed order
      `CHK({w1, w2}, {7'h63, {pde, pvs, phs, b[5:2]}})
      rd(8'h7c, 32'h1f, 1'b0); // lane status
      apb(1'b1, 8'h24, 32'h1); // soft reset clears lanes
      rd(8'h24, 32'h0, 1'b0); // write-only, reads as zero
      rd(8'h68, 32'h22, 1'b0); // bank kept
      pix(2'b10, 3'b000); // lanes resume
      stop_test();
   end
endmodule : tb
`default_nettype wire
